// ### verification/dma_agent_model.sv
`timescale 1ns/1ps
module dma_agent_model (
    // clock
    input  wire logic ref_clk,
    // serial pins
    input  wire logic gntLine,
    output logic      reqLine,
    // decoded grant
    output logic [2:0] gntCh,
    output logic       gntSeen
);
    logic [1:0] bitCnt;
    logic       active;
    initial begin
        reqLine = 1'b1;
        gntSeen = 1'b0;
        active = 1'b0;
        bitCnt = 2'h0;
        gntCh = 3'h0;
    end
    // ==========================================================
    // grant receiver, free of the request sender
    always @(posedge ref_clk) begin
        if (!active && !gntSeen && gntLine === 1'b0) begin
            active <= 1'b1;
            bitCnt <= 2'h0;
        end else if (active) begin
            gntCh[bitCnt] <= gntLine;
            bitCnt <= bitCnt + 2'h1;
            if (bitCnt == 2'h2) begin
                active <= 1'b0;
                gntSeen <= 1'b1;
            end
        end else if (gntLine === 1'b1) begin
            gntSeen <= 1'b0;
        end
    end
    // ==========================================================
    // request frame: idle gap, low start, slots 0..7
    task automatic send(input logic [7:0] slots, input int gap);
        repeat (gap) @(negedge ref_clk);
        reqLine = 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(negedge ref_clk);
            reqLine = slots[k];
        end
        @(negedge ref_clk);
        reqLine = 1'b1;
    endtask
endmodule // dma_agent_model

// ### verification/pc_pci_dma_expansion_tb.sv
`timescale 1ns/1ps
module pc_pci_dma_expansion_tb;
    import pc_dma_pkg::*;
    // ==========================================================
    // signals
    logic ref_clk = 1'b0, rstn = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0, ioWrite = 1'b0;
    logic cmdReady = 1'b0, cmdDone = 1'b0, agentReq, agentReqB, chanBusy, xferDone, cmdValid;
    logic [1:0] gntSeen;
    logic [7:0] cfgAddr = 8'h00, maskBits, lpcRoute, lpcWord;
    logic [15:0] cfgWdata = 16'h0000, ioAddr = 16'h0000, cfgRdata, r;
    logic [31:0] chanMemAddr = 32'h0000_1000, cmdRdData = 32'h0000_0000;
    logic [2:0] activeChan, gntCh, gntChB;
    logic [1:0] dmaGntLine;
    chan_mode_type chanMode = '0;
    pci_cmd_type cmdOut, c;
    int mismatches = 0, tests_run = 0, dones = 0;
    always #50 ref_clk = ~ref_clk;
    pc_pci_dma_expansion i_dut (.ref_clk(ref_clk), .rstn(rstn), .cfgWrite(cfgWrite),
        .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
        .ioWrite(ioWrite), .ioAddr(ioAddr), .dmaReqLine({agentReqB, agentReq}),
        .dmaGntLine(dmaGntLine), .chanMemAddr(chanMemAddr), .chanMode(chanMode),
        .activeChan(activeChan), .chanBusy(chanBusy), .xferDone(xferDone),
        .maskBits(maskBits), .lpcRoute(lpcRoute), .lpcWord(lpcWord), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdOut(cmdOut), .cmdDone(cmdDone), .cmdRdData(cmdRdData));
    dma_agent_model i_agent (.ref_clk(ref_clk), .gntLine(dmaGntLine[0]), .reqLine(agentReq),
        .gntCh(gntCh), .gntSeen(gntSeen[0]));
    dma_agent_model i_agentB (.ref_clk(ref_clk), .gntLine(dmaGntLine[1]), .reqLine(agentReqB),
        .gntCh(gntChB), .gntSeen(gntSeen[1]));
    always @(negedge ref_clk) begin
        if (xferDone === 1'b1) begin
            dones++;
        end
    end
    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        cfgWrite = wr;
        cfgRead = !wr;
        cfgAddr = a;
        cfgWdata = d;
        @(negedge ref_clk);
        r = cfgRdata;
        cfgWrite = 1'b0;
        cfgRead = 1'b0;
    endtask
    task automatic io_cmd(input logic [15:0] a);
        @(negedge ref_clk);
        ioWrite = 1'b1;
        ioAddr = a;
        @(negedge ref_clk);
        ioWrite = 1'b0;
    endtask
    task automatic until_gnt(input int p, input logic lvl);
        int n;
        n = 0;
        while (gntSeen[p] !== lvl && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        chk(32'(gntSeen[p]), 32'(lvl));
    endtask
    // stall the command for two cycles, then accept and finish it
    task automatic take(input logic [31:0] rd);
        int n;
        n = 0;
        while (cmdValid !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        c = cmdOut;
        repeat (2) @(negedge ref_clk);
        chk(32'(cmdValid), 32'h1);
        chk(32'(cmdOut), 32'(c));
        cmdReady = 1'b1;
        @(negedge ref_clk);
        cmdReady = 1'b0;
        cmdDone = 1'b1;
        cmdRdData = rd;
        @(negedge ref_clk);
        cmdDone = 1'b0;
    endtask
    // ==========================================================
    // scenarios
    task automatic regs_test();
        chk(32'(maskBits), 32'(MASK_RESET));
        cfg(1'b0, STYLE_OFFSET, 16'h0000);
        chk(32'(r), 32'(STYLE_RESET));
        chk(32'(lpcWord), 32'h00e0);
        cfg(1'b1, STYLE_OFFSET, 16'h0405);
        cfg(1'b0, STYLE_OFFSET, 16'h0000);
        chk(32'(r), 32'h0405);
        chk(32'(lpcRoute), 32'h00bc);
        cfg(1'b0, 8'h94, 16'h0000);
        chk(32'(r), 32'h0000);
    endtask
    task automatic mask_test();
        io_cmd(16'h0040);
        chk(32'(maskBits), 32'h00ff);
        io_cmd(CLR_MASK_LO);
        chk(32'(maskBits), 32'h00f0);
        io_cmd(CLR_MASK_HI);
        chk(32'(maskBits), 32'h0000);
    endtask
    task automatic io_to_mem();
        chanMode = 5'b00010;
        i_agent.send(8'h40, 0);
        until_gnt(0, 1'b1);
        chk(32'(gntCh), 32'h6);
        chk(32'(activeChan), 32'h6);
        take(32'h1234_56a5);
        chk({c.isIo, c.isWrite, c.byteEn}, {2'b10, BE_WORD});
        chk(c.addr, IO_NORMAL_TC);
        take(32'h0);
        chk({c.isIo, c.isWrite}, 2'b01);
        chk(c.addr, chanMemAddr);
        chk(c.data & 32'h0000_ffff, 32'h56a5);
        until_gnt(0, 1'b0);
        chk(32'(maskBits[6]), 32'h1);
    endtask
    task automatic mem_to_io();
        chanMode = 5'b10010;
        i_agent.send(8'h01, 2);
        until_gnt(0, 1'b1);
        chk(32'(gntCh), 32'h0);
        take(32'h0000_0077);
        chk({c.isIo, c.isWrite}, 2'b00);
        chk(c.addr, chanMemAddr);
        take(32'h0);
        chk({c.isIo, c.isWrite, c.byteEn}, {2'b11, BE_BYTE});
        chk(c.addr, IO_NORMAL_TC);
        chk(c.data & 32'h0000_00ff, 32'h77);
        until_gnt(0, 1'b0);
    endtask
    task automatic verify_test();
        chanMode = 5'b01010;
        i_agent.send(8'h02, 2);
        until_gnt(0, 1'b1);
        chk(32'(gntCh), 32'h1);
        take(32'h0000_0033);
        chk({c.isIo, c.isWrite}, 2'b10);
        chk(c.addr, IO_VERIFY_TC);
        until_gnt(0, 1'b0);
    endtask
    // no terminal count: the agent drops its request and the transfer ends
    task automatic stop_test();
        io_cmd(CLR_MASK_LO);
        chanMode = 5'b00000;
        chanMemAddr = 32'h0000_1001;
        i_agent.send(8'h02, 2);
        until_gnt(0, 1'b1);
        chk(32'(chanBusy), 32'h1);
        i_agent.send(8'h00, 1);
        take(32'h1234_125a);
        chk(c.addr, IO_NORMAL);
        chk(32'(c.byteEn), 32'(BE_BYTE));
        take(32'h0);
        chk(c.data, 32'h0000_5a00);
        chk(32'(c.byteEn), 32'hd);
        until_gnt(0, 1'b0);
        chk(32'(maskBits[1]), 32'h0);
        chk(32'(chanBusy), 32'h0);
        chk(32'(dones), 32'h4);
    endtask
    // cascade on the second pair: grant held until the request is gone
    task automatic cascade_test();
        cfg(1'b1, STYLE_OFFSET, 16'h0605);
        chanMode = 5'b00001;
        i_agentB.send(8'h20, 0);
        until_gnt(1, 1'b1);
        chk(32'(gntChB), 32'h5);
        chk(32'(lpcRoute), 32'h009c);
        chk(32'({chanBusy, cmdValid}), 32'h2);
        i_agentB.send(8'h00, 1);
        until_gnt(1, 1'b0);
        chk(32'(chanBusy), 32'h0);
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        regs_test();
        mask_test();
        io_to_mem();
        mem_to_io();
        verify_test();
        stop_test();
        cascade_test();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        end_of_test();
    end
endmodule // pc_pci_dma_expansion_tb

// ### verilog/cmd_buffer2.sv
`timescale 1ns/1ps
module cmd_buffer2
    import pc_dma_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstSyncN,
    // filling side
    input  wire logic        inValid,
    output logic             inReady,
    input  wire pci_cmd_type inData,
    // draining side
    output logic             outValid,
    input  wire logic        outReady,
    output pci_cmd_type      outData
);
    typedef struct packed {
        logic        v0;
        logic        v1;
        pci_cmd_type d0;
        pci_cmd_type d1;
    } buf_state_type;

    buf_state_type s_q;
    buf_state_type s_d;

    // ==========================================================
    // head always in entry 0, so the outputs are flops
    always_comb begin
        s_d = s_q;
        if (s_q.v0 && outReady) begin
            s_d.d0 = s_q.d1;
            s_d.v0 = s_q.v1;
            s_d.v1 = 1'b0;
        end
        if (inValid && !s_q.v1) begin
            if (s_d.v0) begin
                s_d.d1 = inData;
                s_d.v1 = 1'b1;
            end else begin
                s_d.d0 = inData;
                s_d.v0 = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign inReady  = !s_q.v1;
    assign outValid = s_q.v0;
    assign outData  = s_q.d0;
endmodule // cmd_buffer2

// ### verilog/pc_dma_pkg.sv
package pc_dma_pkg;
    // ==========================================================
    // sizes and register map
    localparam int          NUM_CH         = 8;
    localparam int          NUM_PAIRS      = 2;
    localparam int          SLOT_COUNT     = 8;
    localparam int          FIELD_W        = 2;
    localparam logic [7:0]  STYLE_OFFSET   = 8'h90;
    localparam logic [15:0] STYLE_RESET    = 16'h0000;
    localparam logic [15:0] CLR_MASK_LO    = 16'h000e;
    localparam logic [15:0] CLR_MASK_HI    = 16'h00dc;
    localparam logic [7:0]  MASK_RESET     = 8'hff;
    localparam logic [1:0]  STYLE_LPC      = 2'h0;
    localparam logic [1:0]  STYLE_PAIR_A   = 2'h1;
    localparam logic [1:0]  STYLE_PAIR_B   = 2'h2;
    // ==========================================================
    // special i/o addresses and byte enables (active low)
    localparam logic [31:0] IO_NORMAL      = 32'h0000_0000;
    localparam logic [31:0] IO_NORMAL_TC   = 32'h0000_0004;
    localparam logic [31:0] IO_VERIFY      = 32'h0000_00c0;
    localparam logic [31:0] IO_VERIFY_TC   = 32'h0000_00c4;
    localparam logic [3:0]  BE_BYTE        = 4'he;
    localparam logic [3:0]  BE_WORD        = 4'hc;
    localparam logic [3:0]  BE_VERIFY      = 4'hf;
    localparam logic [3:0]  LANE_BYTE      = 4'h1;
    localparam logic [3:0]  LANE_WORD      = 4'h3;
    localparam logic [15:0] BYTE_DATA_MASK = 16'h00ff;
    // ==========================================================
    // channel numbering and serial framing
    localparam logic [2:0]  BUS_MASTER_CH  = 3'h4;
    localparam logic [2:0]  FIRST_WORD_CH  = 3'h5;
    localparam logic [1:0]  LAST_GRANT_BIT = 2'h2;
    localparam logic [2:0]  LAST_SLOT      = 3'h7;
    // ==========================================================
    // types
    typedef enum logic [3:0] {
        ST_IDLE, ST_GRANT, ST_FIRST_REQ, ST_FIRST_WAIT, ST_SECOND_REQ,
        ST_SECOND_WAIT, ST_CHECK, ST_CASCADE, ST_RELEASE
    } dma_state_type;
    typedef struct packed {
        logic        isIo;
        logic        isWrite;
        logic [31:0] addr;
        logic [3:0]  byteEn;
        logic [31:0] data;
    } pci_cmd_type;
    typedef struct packed {
        logic toIo;
        logic verify;
        logic autoInit;
        logic termCount;
        logic cascade;
    } chan_mode_type;
endpackage

// ### verilog/pc_pci_dma_expansion.sv
// Function
// - clear-mask port write unmasks four channels; one reaching terminal count in that same cycle stays masked
// - after request and bus, two-cycle transfer
// - two serial request/grant pairs
// - 16-bit register, seven 2-bit style fields
// - one style per channel, channels independent
// - grant: low start, three bits LSB first
// - mem-io, io-mem, verify, cascade bus masters
// - load then store; memory read or write
// - io addresses 00h/04h, verify 0C0h/0C4h
// - special io cycles only under active grant
// - io read data on low bus bytes
// - one io read per memory write, no packing
// - byte enables 1110b byte, 1100b word
// - end at terminal count or dropped request; with autoInit set, only a dropped request ends it
// - lpc channels: 0-3 byte, 5-7 word, 4 master
`timescale 1ns/1ps
module pc_pci_dma_expansion
    import pc_dma_pkg::*;
(
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    // configuration space and command ports
    input  wire logic          cfgWrite,
    input  wire logic          cfgRead,
    input  wire logic [7:0]    cfgAddr,
    input  wire logic [15:0]   cfgWdata,
    output logic [15:0]        cfgRdata,
    input  wire logic          ioWrite,
    input  wire logic [15:0]   ioAddr,
    // serial request and grant pins
    input  wire logic [1:0]    dmaReqLine,
    output logic [1:0]         dmaGntLine,
    // dma controller side
    input  wire logic [31:0]   chanMemAddr,
    input  wire chan_mode_type chanMode,
    output logic [2:0]         activeChan,
    output logic               chanBusy,
    output logic               xferDone,
    output logic [7:0]         maskBits,
    output logic [7:0]         lpcRoute,
    output logic [7:0]         lpcWord,
    // pci master command stream
    output logic               cmdValid,
    input  wire logic          cmdReady,
    output pci_cmd_type        cmdOut,
    input  wire logic          cmdDone,
    input  wire logic [31:0]   cmdRdData
);
    typedef struct packed {
        dma_state_type     st;
        logic              pair;
        logic [2:0]        chan;
        logic [1:0]        bitCnt;
        logic [15:0]       styleSel;
        logic [7:0]        mask;
        logic [1:0][7:0]   stale;
        logic [15:0]       cfgRdata;
        logic [1:0]        gnt;
        logic              busy;
        logic              xferDone;
        logic [15:0]       ioData;
        chan_mode_type     modeLat;
        logic [31:0]       addrLat;
        logic [7:0]        lpcRoute;
        logic [7:0]        lpcWord;
    } top_state_type;

    localparam top_state_type TOP_RESET = '{st: ST_IDLE, styleSel: STYLE_RESET,
                                             mask: MASK_RESET, gnt: 2'h3, default: '0};

    logic            rstMeta;
    logic            rstSyncN;
    top_state_type   s_q;
    top_state_type   s_d;
    logic [1:0][7:0] pend;
    logic [1:0]      frameDone;
    logic            bufInValid;
    logic            bufInReady;
    pci_cmd_type     bufIn;

    // ==========================================================
    // reset release
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // ==========================================================
    // request receivers, one per pair
    for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_rx
        req_serial_rx u_rx (
            .ref_clk   (ref_clk),
            .rstSyncN  (rstSyncN),
            .reqLine   (dmaReqLine[p]),
            .pending   (pend[p]),
            .frameDone (frameDone[p])
        );
    end

    // ==========================================================
    // helpers
    function automatic logic [1:0] styleOf(input logic [15:0] sel, input logic [2:0] ch);
        logic [2:0] idx;
        idx = (ch > BUS_MASTER_CH) ? ch - 3'h1 : ch;
        return sel[idx*FIELD_W +: FIELD_W];
    endfunction

    function automatic logic [2:0] firstSet(input logic [7:0] v);
        logic [2:0] r;
        r = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // ==========================================================
    // state machine and registers
    always_comb begin
        logic [1:0][7:0] elig;
        logic            isWord;
        logic            tcNow;
        logic            verNow;
        logic [1:0]      lane;
        logic [31:0]     ioTarget;
        logic [3:0]      ioBe;
        logic [3:0]      memBe;
        logic [31:0]     rdShift;
        chan_mode_type   md;
        s_d          = s_q;
        s_d.xferDone = 1'b0;
        bufInValid   = 1'b0;
        bufIn        = '0;
        elig         = '0;
        md           = (s_q.st == ST_FIRST_REQ) ? chanMode : s_q.modeLat;
        isWord       = s_q.chan >= FIRST_WORD_CH;
        tcNow        = md.termCount;
        verNow       = md.verify;
        lane         = (s_q.st == ST_FIRST_REQ) ? chanMemAddr[1:0] : s_q.addrLat[1:0];
        ioTarget     = verNow ? (tcNow ? IO_VERIFY_TC : IO_VERIFY)
                              : (tcNow ? IO_NORMAL_TC : IO_NORMAL);
        ioBe         = verNow ? BE_VERIFY : (isWord ? BE_WORD : BE_BYTE);
        memBe        = ~((isWord ? LANE_WORD : LANE_BYTE) << lane);
        rdShift      = cmdRdData >> {lane, 3'h0};
        for (int c = 0; c < NUM_CH; c++) begin
            for (int p = 0; p < NUM_PAIRS; p++) begin
                elig[p][c] = pend[p][c] && !s_q.mask[c] && !s_q.stale[p][c]
                             && (3'(c) != BUS_MASTER_CH)
                             && styleOf(s_q.styleSel, 3'(c))
                                == (p != 0 ? STYLE_PAIR_B : STYLE_PAIR_A);
            end
            s_d.lpcRoute[c] = (3'(c) == BUS_MASTER_CH)
                              || (styleOf(s_q.styleSel, 3'(c)) != STYLE_PAIR_A
                                  && styleOf(s_q.styleSel, 3'(c)) != STYLE_PAIR_B);
            s_d.lpcWord[c]  = 3'(c) >= FIRST_WORD_CH;
        end
        s_d.cfgRdata = (cfgRead && cfgAddr == STYLE_OFFSET) ? s_q.styleSel : '0;
        if (cfgWrite && cfgAddr == STYLE_OFFSET) begin
            s_d.styleSel = cfgWdata;
        end
        if (ioWrite && ioAddr == CLR_MASK_LO) begin
            s_d.mask[3:0] = '0;
        end
        if (ioWrite && ioAddr == CLR_MASK_HI) begin
            s_d.mask[7:4] = '0;
        end
        for (int p = 0; p < NUM_PAIRS; p++) begin
            if (frameDone[p]) begin
                s_d.stale[p] = '0;
            end
        end
        unique case (s_q.st)
            ST_IDLE: begin
                if (|elig[0] || |elig[1]) begin
                    s_d.pair          = !(|elig[0]);
                    s_d.chan          = firstSet(|elig[0] ? elig[0] : elig[1]);
                    s_d.gnt[s_d.pair] = 1'b0;
                    s_d.bitCnt        = '0;
                    s_d.st            = ST_GRANT;
                end
            end
            ST_GRANT: begin
                s_d.gnt[s_q.pair] = s_q.chan[s_q.bitCnt];
                s_d.bitCnt        = s_q.bitCnt + 2'h1;
                if (s_q.bitCnt == LAST_GRANT_BIT) begin
                    s_d.st = chanMode.cascade ? ST_CASCADE : ST_FIRST_REQ;
                end
            end
            ST_CASCADE: begin
                s_d.gnt[s_q.pair] = 1'b0;
                if (frameDone[s_q.pair] && !pend[s_q.pair][s_q.chan]) begin
                    s_d.st = ST_RELEASE;
                end
            end
            ST_FIRST_REQ: begin
                s_d.gnt[s_q.pair] = 1'b0;
                bufInValid        = 1'b1;
                if (chanMode.toIo && !verNow) begin
                    bufIn = '{isIo: 1'b0, isWrite: 1'b0, addr: chanMemAddr,
                              byteEn: memBe, data: '0};
                end else begin
                    bufIn = '{isIo: 1'b1, isWrite: 1'b0, addr: ioTarget,
                              byteEn: ioBe, data: '0};
                end
                if (bufInReady) begin
                    s_d.modeLat = chanMode;
                    s_d.addrLat = chanMemAddr;
                    s_d.st      = ST_FIRST_WAIT;
                end
            end
            ST_FIRST_WAIT: begin
                if (cmdDone) begin
                    s_d.ioData = s_q.modeLat.toIo ? rdShift[15:0] : cmdRdData[15:0];
                    if (!isWord) begin
                        s_d.ioData = s_d.ioData & BYTE_DATA_MASK;
                    end
                    s_d.xferDone = s_q.modeLat.verify;
                    s_d.st       = s_q.modeLat.verify ? ST_CHECK : ST_SECOND_REQ;
                end
            end
            ST_SECOND_REQ: begin
                bufInValid = 1'b1;
                if (s_q.modeLat.toIo) begin
                    bufIn = '{isIo: 1'b1, isWrite: 1'b1, addr: ioTarget,
                              byteEn: ioBe, data: {16'h0000, s_q.ioData}};
                end else begin
                    bufIn = '{isIo: 1'b0, isWrite: 1'b1, addr: s_q.addrLat, byteEn: memBe,
                              data: {16'h0000, s_q.ioData} << {lane, 3'h0}};
                end
                if (bufInReady) begin
                    s_d.st = ST_SECOND_WAIT;
                end
            end
            ST_SECOND_WAIT: begin
                if (cmdDone) begin
                    s_d.xferDone = 1'b1;
                    s_d.st       = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (s_q.modeLat.termCount && !s_q.modeLat.autoInit) begin
                    s_d.mask[s_q.chan] = 1'b1;
                    s_d.st             = ST_RELEASE;
                end else if (!pend[s_q.pair][s_q.chan]) begin
                    s_d.st = ST_RELEASE;
                end else begin
                    s_d.st = ST_FIRST_REQ;
                end
            end
            ST_RELEASE: begin
                s_d.gnt[s_q.pair]            = 1'b1;
                s_d.stale[s_q.pair][s_q.chan] = 1'b1;
                s_d.st                       = ST_IDLE;
            end
        endcase
        s_d.busy = s_d.st != ST_IDLE;
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_q <= TOP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // command buffer towards the pci master
    cmd_buffer2 u_buf (
        .ref_clk  (ref_clk),
        .rstSyncN (rstSyncN),
        .inValid  (bufInValid),
        .inReady  (bufInReady),
        .inData   (bufIn),
        .outValid (cmdValid),
        .outReady (cmdReady),
        .outData  (cmdOut)
    );

    assign cfgRdata   = s_q.cfgRdata;
    assign dmaGntLine = s_q.gnt;
    assign activeChan = s_q.chan;
    assign chanBusy   = s_q.busy;
    assign xferDone   = s_q.xferDone;
    assign maskBits   = s_q.mask;
    assign lpcRoute   = s_q.lpcRoute;
    assign lpcWord    = s_q.lpcWord;

    // ==========================================================
    // assertions
    function automatic logic verNowA();
        return (s_q.st == ST_FIRST_REQ) ? chanMode.verify : s_q.modeLat.verify;
    endfunction

    function automatic logic tcNowA();
        return (s_q.st == ST_FIRST_REQ) ? chanMode.termCount : s_q.modeLat.termCount;
    endfunction

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstSyncN);

    a_mask_clear_lo: assert property (ioWrite && ioAddr == CLR_MASK_LO
        && s_q.st != ST_CHECK |=> maskBits[3:0] == 4'h0)
        else $error("low mask group not cleared");
    a_mask_clear_hi: assert property (ioWrite && ioAddr == CLR_MASK_HI
        && s_q.st != ST_CHECK |=> maskBits[7:4] == 4'h0)
        else $error("high mask group not cleared");
    a_grant_bits_order: assert property ($rose(s_q.st == ST_GRANT)
        |-> dmaGntLine[s_q.pair] == 1'b0 ##1 dmaGntLine[s_q.pair] == s_q.chan[0]
        ##1 dmaGntLine[s_q.pair] == s_q.chan[1] ##1 dmaGntLine[s_q.pair] == s_q.chan[2])
        else $error("grant sequence wrong");
    a_grant_style_match: assert property (s_q.st == ST_FIRST_REQ
        |-> styleOf(s_q.styleSel, s_q.chan) == (s_q.pair ? STYLE_PAIR_B : STYLE_PAIR_A))
        else $error("channel granted on wrong style");
    a_io_addr_table: assert property (bufInValid && bufIn.isIo
        |-> bufIn.addr == (verNowA() ? (tcNowA() ? IO_VERIFY_TC : IO_VERIFY)
                                     : (tcNowA() ? IO_NORMAL_TC : IO_NORMAL)))
        else $error("special io address wrong");
    a_io_byte_enables: assert property (bufInValid && bufIn.isIo && !verNowA()
        |-> bufIn.byteEn == (s_q.chan >= FIRST_WORD_CH ? BE_WORD : BE_BYTE))
        else $error("io byte enables wrong");
    a_io_under_grant: assert property (cmdValid && cmdOut.isIo
        |-> dmaGntLine[s_q.pair] == 1'b0 && chanBusy)
        else $error("special io cycle without grant");
    a_load_then_store: assert property (s_q.st == ST_FIRST_WAIT && cmdDone
        && !s_q.modeLat.verify |=> bufInValid && bufIn.isWrite
        && bufIn.isIo == s_q.modeLat.toIo)
        else $error("second cycle does not pair the first");
    a_end_at_tc: assert property (s_q.st == ST_CHECK && s_q.modeLat.termCount
        && !s_q.modeLat.autoInit |=> maskBits[s_q.chan] ##1 dmaGntLine[s_q.pair])
        else $error("transfer not ended at terminal count");
endmodule // pc_pci_dma_expansion

// ### verilog/req_serial_rx.sv
`timescale 1ns/1ps
module req_serial_rx
    import pc_dma_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstSyncN,
    // serial request pin
    input  wire logic       reqLine,
    // decoded frame
    output logic [7:0]      pending,
    output logic            frameDone
);
    typedef struct packed {
        logic       meta;
        logic       line;
        logic       busy;
        logic [2:0] slot;
        logic [7:0] shift;
        logic [7:0] pending;
        logic       frameDone;
    } rx_state_type;

    localparam rx_state_type RX_RESET = '{meta: 1'b1, line: 1'b1, default: '0};

    rx_state_type s_q;
    rx_state_type s_d;

    // ==========================================================
    // start bit then eight slots, channel 0 first
    always_comb begin
        s_d           = s_q;
        s_d.meta      = reqLine;
        s_d.line      = s_q.meta;
        s_d.frameDone = 1'b0;
        if (!s_q.busy) begin
            if (!s_q.line) begin
                s_d.busy = 1'b1;
                s_d.slot = '0;
            end
        end else begin
            s_d.shift[s_q.slot] = s_q.line;
            s_d.slot            = s_q.slot + 3'h1;
            if (s_q.slot == LAST_SLOT) begin
                s_d.busy      = 1'b0;
                s_d.pending   = {s_q.line, s_q.shift[SLOT_COUNT-2:0]};
                s_d.frameDone = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_q <= RX_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign pending   = s_q.pending;
    assign frameDone = s_q.frameDone;
endmodule // req_serial_rx
